// ===== inc/row_alert_pkg.sv
// constants for the row-boundary pulse and alert logic
// assumes a 10 MHz system clock and a plain register port
package row_alert_pkg;

  // system clock rate
  localparam longint CLK_HZ = 64'd10_000_000;
  // sampling rate at which the nominal times hold
  localparam int unsigned REF_HZ = 32'd8000;

  // nominal times at the reference rate, in nanoseconds
  localparam longint ROW_HIGH_NS = 64'd175_000_000;
  localparam longint ROW_LOW_NS  = 64'd25_000_000;
  localparam longint CUE_HIGH_NS = 64'd109_370;
  localparam longint CUE_LOW_NS  = 64'd15_630;

  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] SNAP_OFS   = 8'h08;

  // control fields
  localparam int CTRL_REC_BIT  = 0;
  localparam int CTRL_PLAY_BIT = 1;
  localparam int CTRL_CUE_BIT  = 2;
  localparam int CTRL_W        = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // status fields
  localparam int ST_MEM_BIT   = 0;
  localparam int ST_MSG_BIT   = 1;
  localparam int ST_ALERT_BIT = 2;
  localparam int ST_ROW_BIT   = 3;
  localparam int ST_PIN_BIT   = 4;
  localparam int ST_BUSY_BIT  = 5;
  localparam int ST_W         = 6;

  // snapshot / alert status fields
  localparam int SNAP_MEM_BIT = 0;
  localparam int SNAP_MSG_BIT = 1;
  localparam logic [1:0] SNAP_RESET = 2'h0;

  // synchroniser lanes: select, row pin, alert pin
  localparam int SYN_CS_BIT  = 0;
  localparam int SYN_ROW_BIT = 1;
  localparam int SYN_ALT_BIT = 2;
  localparam logic [2:0] SYN_RESET = 3'h7;

  // clock cycles for a time, scaled inversely to the sample rate
  function automatic longint cycles_of(longint t_ns, int unsigned hz);
    longint c;
    c = (t_ns * CLK_HZ / 64'd1_000_000_000) * REF_HZ / hz;
    return (c < 64'd1) ? 64'd1 : c;
  endfunction : cycles_of

endpackage : row_alert_pkg

// ===== logic/row_pulse_and_alert_logic.sv
// row-boundary pulse generator and end-of-operation alert logic
// assumes the array controller sends same-clock event pulses and the
// serial decoder a same-clock pulse for the alert status instruction
//
// What this block does
// (R1) row pulse period 200 ms at 8 KHz
// (R2) normal row: high 175 ms, low 25 ms
// (R3) cue mode: high 109.37 us, low 15.63 us
// (R4) record start from idle: extra row low time high
// (R5) row pin only pulled low or released
// (R6) alert pin only pulled low or released
// (R7) flagged termination pulls alert low, stays low
// (R8) serial transaction start releases, clears alert
// (R9) alert status instruction reports both flags
// (R10) memory end flag in record or playback
// (R11) message end flag only in playback
// (R12) row timing scales inversely with sample rate
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module row_pulse_and_alert_logic #(
  parameter int unsigned SAMPLE_HZ    = row_alert_pkg::REF_HZ,
  parameter int unsigned CNT_W        = 24,
  parameter longint      ROW_HIGH_CYC = row_alert_pkg::cycles_of(
                           row_alert_pkg::ROW_HIGH_NS, SAMPLE_HZ),
  parameter longint      ROW_LOW_CYC  = row_alert_pkg::cycles_of(
                           row_alert_pkg::ROW_LOW_NS, SAMPLE_HZ)
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // array controller events
  input  wire logic        mem_end_i,
  input  wire logic        marker_i,
  // serial decoder side
  input  wire logic        read_alert_status_cmd_i,
  output logic      [1:0]  alert_status_o,
  input  wire logic        spi_cs_n_i,
  // row-boundary open-drain pin
  input  wire logic        row_boundary_pulse_i,
  output logic             row_boundary_pulse_o,
  output logic             row_boundary_pulse_oe_o,
  // alert open-drain pin
  input  wire logic        alert_n_i,
  output logic             alert_n_o,
  output logic             alert_n_oe_o
);

  // cue mode counts, scaled with the sample rate
  localparam longint CUE_HIGH_CYC = row_alert_pkg::cycles_of(
                       row_alert_pkg::CUE_HIGH_NS, SAMPLE_HZ); // see (R3)
  localparam longint CUE_LOW_CYC  = row_alert_pkg::cycles_of(
                       row_alert_pkg::CUE_LOW_NS, SAMPLE_HZ);  // see (R12)
  localparam longint CNT_MAX      = (64'd1 << CNT_W) - 64'd1;

  // elaboration check on counts and widths
  if (SAMPLE_HZ == 0 || CNT_W < 2 || CNT_W > 32 ||
      ROW_HIGH_CYC < 1 || ROW_LOW_CYC < 1 ||
      ROW_HIGH_CYC > CNT_MAX || ROW_LOW_CYC > CNT_MAX ||
      CUE_HIGH_CYC > CNT_MAX) begin : g_bad_cfg
    $error("row timing counts do not fit the counter");
  end

  // phase lengths minus one, at counter width
  localparam logic [CNT_W-1:0] HI_N  = CNT_W'(ROW_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] LO_N  = CNT_W'(ROW_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] CHI_N = CNT_W'(CUE_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] CLO_N = CNT_W'(CUE_LOW_CYC - 1);

  // row sequencer states
  typedef enum logic [1:0] {
    ROW_IDLE,
    ROW_PRIME,
    ROW_HIGH,
    ROW_LOW
  } row_state_e;

  // address match for the register port
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // state
  logic [2:0]       ctrl;       // record, play, cue bits
  logic             mem_flag;   // memory end reached
  logic             msg_flag;   // end-of-message found
  logic [1:0]       snap;       // flags at last transaction start
  logic [2:0]       syn_a;      // first synchroniser stage
  logic [2:0]       syn_b;      // second stage
  logic [2:0]       syn_c;      // third stage
  logic [2:0]       filt;       // agreed input levels
  logic             cs_prev;    // select level one cycle ago
  row_state_e       state;      // row sequencer state
  logic [CNT_W-1:0] cnt;        // phase down-counter

  // next values
  logic [2:0]       next_ctrl;
  logic             next_mem_flag;
  logic             next_msg_flag;
  logic [2:0]       next_filt;
  row_state_e       next_state;
  logic [CNT_W-1:0] next_cnt;
  logic [31:0]      next_rdata;

  // status word width
  localparam int ST_W_L = row_alert_pkg::ST_W;

  // decode wires
  wire logic       ctrl_wr;     // control register write
  wire logic [2:0] ctrl_wv;     // control value after a write
  wire logic       txn_start;   // serial transaction begins
  wire logic       rec_on;      // recording in progress
  wire logic       play_on;     // playback in progress
  wire logic       mem_set;     // memory end event
  wire logic       msg_set;     // message marker event
  wire logic       term;        // operation ends on a flag
  wire logic       rec_start;   // record begins this cycle
  wire logic       busy_next;   // an operation runs next cycle
  wire logic       cue;         // fast message-skipping mode
  wire logic       cnt_done;    // current phase ends
  wire logic [CNT_W-1:0] hi_n;  // high phase length minus one
  wire logic [CNT_W-1:0] lo_n;  // low phase length minus one
  wire logic [ST_W_L-1:0] status_v; // assembled status word

  // control write decode
  assign ctrl_wr = wr_i & hit(addr_i, row_alert_pkg::CTRL_OFS);
  assign ctrl_wv = ctrl_wr ? wdata_i[2:0] : ctrl;

  // operation qualifiers
  assign rec_on  = ctrl[row_alert_pkg::CTRL_REC_BIT];
  assign play_on = ctrl[row_alert_pkg::CTRL_PLAY_BIT] & ~rec_on;
  // cue bit as it will stand, so a phase loaded by a write obeys it
  assign cue     = next_ctrl[row_alert_pkg::CTRL_CUE_BIT]; // see (R3)

  // flag events
  assign mem_set = mem_end_i & (rec_on | play_on);  // see (R10)
  assign msg_set = marker_i & play_on;              // see (R11)
  assign term    = mem_set | msg_set;               // see (R7)

  // transaction start is a falling edge of the agreed select level
  assign txn_start = cs_prev & ~filt[row_alert_pkg::SYN_CS_BIT];

  // flags: an event in the clearing cycle wins
  assign next_mem_flag = mem_set | (mem_flag & ~txn_start); // see (R8)
  assign next_msg_flag = msg_set | (msg_flag & ~txn_start); // see (R8)

  // a flagged termination stops record and playback
  always_comb begin
    next_ctrl = ctrl_wv;
    if (term) begin // see (R7)
      next_ctrl[row_alert_pkg::CTRL_REC_BIT]  = 1'b0;
      next_ctrl[row_alert_pkg::CTRL_PLAY_BIT] = 1'b0;
    end
  end

  // sequencer qualifiers
  assign busy_next = next_ctrl[row_alert_pkg::CTRL_REC_BIT] |
                     next_ctrl[row_alert_pkg::CTRL_PLAY_BIT];
  assign rec_start = next_ctrl[row_alert_pkg::CTRL_REC_BIT] & ~rec_on;
  assign cnt_done  = cnt == '0;
  assign hi_n      = cue ? CHI_N : HI_N;  // see (R3)
  assign lo_n      = cue ? CLO_N : LO_N;  // see (R2)

  // a change counts once the second and third stages agree
  assign next_filt = (syn_b & syn_c) | (filt & (syn_b ^ syn_c));

  // row sequencer next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt_done ? cnt : cnt - CNT_W'(1);
    unique case (state)
      ROW_IDLE: begin
        if (busy_next && rec_start) begin
          next_state = ROW_PRIME;  // see (R4)
          next_cnt   = lo_n;
        end else if (busy_next) begin
          next_state = ROW_HIGH;   // see (R1)
          next_cnt   = hi_n;
        end
      end
      ROW_PRIME: begin
        if (cnt_done) begin
          next_state = ROW_HIGH;
          next_cnt   = hi_n;
        end
      end
      ROW_HIGH: begin
        if (cnt_done) begin
          next_state = ROW_LOW;    // see (R2)
          next_cnt   = lo_n;
        end
      end
      ROW_LOW: begin
        if (cnt_done) begin
          next_state = ROW_HIGH;   // see (R1)
          next_cnt   = hi_n;
        end
      end
    endcase
    if (!busy_next) begin
      next_state = ROW_IDLE;
      next_cnt   = '0;
    end
  end

  // status word
  assign status_v = {
    rec_on | play_on,
    filt[row_alert_pkg::SYN_ALT_BIT],
    filt[row_alert_pkg::SYN_ROW_BIT],
    mem_flag | msg_flag,
    msg_flag,
    mem_flag
  };

  // read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    if (rd_i && hit(addr_i, row_alert_pkg::CTRL_OFS)) begin
      next_rdata = {29'h0, ctrl};
    end else if (rd_i && hit(addr_i, row_alert_pkg::STATUS_OFS)) begin
      next_rdata = {26'h0, status_v};
    end else if (rd_i && hit(addr_i, row_alert_pkg::SNAP_OFS)) begin
      next_rdata = {30'h0, snap};
    end
  end

  // input synchroniser, three stages
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      syn_a   <= row_alert_pkg::SYN_RESET;
      syn_b   <= row_alert_pkg::SYN_RESET;
      syn_c   <= row_alert_pkg::SYN_RESET;
      filt    <= row_alert_pkg::SYN_RESET;
      cs_prev <= 1'b1;
    end else begin
      syn_a   <= {alert_n_i, row_boundary_pulse_i, spi_cs_n_i};
      syn_b   <= syn_a;
      syn_c   <= syn_b;
      filt    <= next_filt;
      cs_prev <= filt[row_alert_pkg::SYN_CS_BIT];
    end
  end

  // control register and flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl     <= row_alert_pkg::CTRL_RESET;
      mem_flag <= 1'b0;
      msg_flag <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      mem_flag <= next_mem_flag;
      msg_flag <= next_msg_flag;
    end
  end

  // flags seen at transaction start, kept for the status instruction
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      snap <= row_alert_pkg::SNAP_RESET;
    end else if (txn_start) begin
      snap <= {msg_flag | msg_set, mem_flag | mem_set}; // see (R9)
    end
  end

  // alert status answer to the status instruction
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alert_status_o <= row_alert_pkg::SNAP_RESET;
    end else if (read_alert_status_cmd_i) begin
      alert_status_o <= snap;  // see (R9)
    end
  end

  // row sequencer registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ROW_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // open-drain pins: value always low, enable pulls the wire
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      row_boundary_pulse_o    <= 1'b0;
      row_boundary_pulse_oe_o <= 1'b0;
      alert_n_o               <= 1'b0;
      alert_n_oe_o            <= 1'b0;
    end else begin
      row_boundary_pulse_o    <= 1'b0;                     // see (R5)
      row_boundary_pulse_oe_o <= next_state == ROW_LOW;    // see (R2)
      alert_n_o               <= 1'b0;                     // see (R6)
      alert_n_oe_o            <= next_mem_flag | next_msg_flag; // see (R7)
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule : row_pulse_and_alert_logic

// ===== testbench/host_model.sv
// host side: serial select, status instruction, pin pull-ups
// assumes both device pins are open drain with pull-ups here
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic clk_sys_i,
  // device pin enables
  input  wire logic row_oe_i,
  input  wire logic alert_oe_i,
  // host drives and wire levels
  output logic      cs_n_o,
  output logic      cmd_o,
  output logic      row_pin_o,
  output logic      alert_pin_o
);
  // pull-ups: a released pin reads high
  assign row_pin_o = row_oe_i ? 1'b0 : 1'b1;
  assign alert_pin_o = alert_oe_i ? 1'b0 : 1'b1;
  initial begin
    cs_n_o = 1'b1;
    cmd_o = 1'b0;
  end
  // one serial cycle; hold sets how slow the host is
  task automatic txn(input int hold);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    repeat (hold) @(posedge clk_sys_i);
    cmd_o <= 1'b1;
    @(posedge clk_sys_i);
    cmd_o <= 1'b0;
    cs_n_o <= 1'b1;
  endtask : txn
endmodule : host_model

// ===== testbench/row_alert_chk_sva.sv
// checker for the row pulse and alert pins of the block
// assumes it is bound to the block top and sees only its ports
`timescale 1ns/1ps
module row_alert_chk #(
  parameter longint ROW_LOW_CYC = 4
) (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  // watched ports
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        mem_end_i,
  input wire logic        marker_i,
  input wire logic        read_alert_status_cmd_i,
  input wire logic [1:0]  alert_status_o,
  input wire logic        spi_cs_n_i,
  input wire logic        row_boundary_pulse_o,
  input wire logic        row_boundary_pulse_oe_o,
  input wire logic        alert_n_o,
  input wire logic        alert_n_oe_o
);
  localparam longint CUE_LO = row_alert_pkg::CUE_LOW_NS / 100;
  logic   op_on;   // record or play running
  logic   play_on; // play without record
  logic   cue_on;  // cue timing chosen
  longint low_cnt; // cycles row pin held low
  longint low_max; // expected low phase
  wire ctl_wr = wr_i && (addr_i == row_alert_pkg::CTRL_OFS);
  wire ev = (mem_end_i && op_on) || (marker_i && play_on);
  assign low_max = cue_on ? CUE_LO : ROW_LOW_CYC;
  // shadow of the control bits and low phase counter
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_on <= 1'b0;
      play_on <= 1'b0;
      cue_on <= 1'b0;
      low_cnt <= 0;
    end else begin
      low_cnt <= row_boundary_pulse_oe_o ? low_cnt + 1 : 0;
      if (ctl_wr) begin
        op_on <= |wdata_i[1:0];
        play_on <= wdata_i[1] && !wdata_i[0];
        cue_on <= wdata_i[2];
      end
      // an event ends the operation even beside a write
      if (ev) begin
        op_on <= 1'b0;
        play_on <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  // select idle long enough that no start is pending
  sequence cs_idle;
    spi_cs_n_i [*7];
  endsequence
  // a filtered serial cycle start with no new event meanwhile
  sequence txn_seen;
    $fell(spi_cs_n_i) ##1 (!spi_cs_n_i && !ev) [*6];
  endsequence
  row_od_a: assert property (!row_boundary_pulse_o)
    else $error("row pin driven high");
  alert_od_a: assert property (!alert_n_o)
    else $error("alert pin driven high");
  alert_set_a: assert property (ev |=> alert_n_oe_o)
    else $error("alert not raised");
  alert_hold_a: assert property (
    cs_idle ##0 alert_n_oe_o |=> alert_n_oe_o)
    else $error("alert dropped");
  alert_clear_a: assert property (txn_seen |=> !alert_n_oe_o)
    else $error("alert not cleared");
  status_hold_a: assert property (
    !read_alert_status_cmd_i |=> $stable(alert_status_o))
    else $error("status moved");
  msg_play_a: assert property (
    marker_i && !play_on && !mem_end_i && !alert_n_oe_o |=> !alert_n_oe_o)
    else $error("marker outside play");
  row_idle_a: assert property (!op_on |-> !row_boundary_pulse_oe_o)
    else $error("row pin low while idle");
  row_low_a: assert property (
    $fell(row_boundary_pulse_oe_o) && op_on |-> low_cnt == low_max)
    else $error("row low phase length");
endmodule : row_alert_chk

bind row_pulse_and_alert_logic row_alert_chk #(
  .ROW_LOW_CYC(ROW_LOW_CYC)
) chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .mem_end_i(mem_end_i),
  .marker_i(marker_i), .read_alert_status_cmd_i(read_alert_status_cmd_i),
  .alert_status_o(alert_status_o), .spi_cs_n_i(spi_cs_n_i),
  .row_boundary_pulse_o(row_boundary_pulse_o),
  .row_boundary_pulse_oe_o(row_boundary_pulse_oe_o),
  .alert_n_o(alert_n_o), .alert_n_oe_o(alert_n_oe_o));

// ===== testbench/tb_top.sv
// bench for the row pulse and alert logic
// assumes short rows set by parameters and a host model
`timescale 1ns/1ps
module tb_top;
  localparam int HI = 20;
  localparam int LO = 4;
  localparam int CUE_HI = int'(row_alert_pkg::CUE_HIGH_NS / 100);
  localparam int CUE_LO = int'(row_alert_pkg::CUE_LOW_NS / 100);
  localparam logic [7:0] CTRL = row_alert_pkg::CTRL_OFS;
  localparam logic [7:0] STAT = row_alert_pkg::STATUS_OFS;
  localparam logic [7:0] SNAP = row_alert_pkg::SNAP_OFS;
  logic clk_sys_i, reset_n_i, wr, rd, mem_end, marker, cmd, cs_n;
  logic row_pin, row_o, row_oe, alert_pin, alert_o, alert_oe;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] status;
  int n_mismatch, n_tests, cyc;
  row_pulse_and_alert_logic #(.ROW_HIGH_CYC(HI), .ROW_LOW_CYC(LO)) uut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .mem_end_i(mem_end), .marker_i(marker),
    .read_alert_status_cmd_i(cmd), .alert_status_o(status),
    .spi_cs_n_i(cs_n), .row_boundary_pulse_i(row_pin),
    .row_boundary_pulse_o(row_o), .row_boundary_pulse_oe_o(row_oe),
    .alert_n_i(alert_pin), .alert_n_o(alert_o), .alert_n_oe_o(alert_oe));
  host_model host (.clk_sys_i(clk_sys_i), .row_oe_i(row_oe),
    .alert_oe_i(alert_oe), .cs_n_o(cs_n), .cmd_o(cmd),
    .row_pin_o(row_pin), .alert_pin_o(alert_pin));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : chk_rd
  task automatic fire(input logic m, input logic k);
    @(posedge clk_sys_i);
    mem_end <= m;
    marker <= k;
    @(posedge clk_sys_i);
    mem_end <= 1'b0;
    marker <= 1'b0;
  endtask : fire
  // delay to first pulse, pulse width, rise to rise period
  task automatic meas(output int d, output int lo, output int per);
    d = 0;
    lo = 0;
    while (row_oe !== 1'b1 && d < 3000) begin
      tick();
      d++;
    end
    while (row_oe === 1'b1 && lo < 3000) begin
      tick();
      lo++;
    end
    per = lo;
    while (row_oe !== 1'b1 && per < 3000) begin
      tick();
      per++;
    end
  endtask : meas
  // reset values, released pins, unmapped place
  task automatic t_regs;
    chk_rd(CTRL, 32'h0);
    chk_rd(STAT, 32'h18);
    chk_rd(SNAP, 32'h0);
    reg_wr(8'hFC, 32'h7);
    chk_rd(8'hFC, 32'h0);
  endtask : t_regs
  // normal, record start and cue row timing
  task automatic t_rows;
    int d1, d2, lo, per;
    reg_wr(CTRL, 32'h2);
    meas(d1, lo, per);
    chk(lo, LO);
    chk(per, HI + LO);
    reg_wr(CTRL, 32'h0);
    reg_wr(CTRL, 32'h1);
    meas(d2, lo, per);
    chk(d2 - d1, LO);
    reg_wr(CTRL, 32'h0);
    reg_wr(CTRL, 32'h6);
    meas(d1, lo, per);
    chk(d1, CUE_HI);
    chk(lo, CUE_LO);
    chk(per, CUE_HI + CUE_LO);
    reg_wr(CTRL, 32'h0);
  endtask : t_rows
  // event during an operation, then clearing by the host
  task automatic t_alert(input logic [31:0] op, input logic m,
                         input logic k, input logic [1:0] f);
    reg_wr(CTRL, op);
    repeat (3) tick();
    fire(m, k);
    repeat (3) tick();
    chk(alert_oe, |f);
    reg_wr(CTRL, 32'h0);
    chk_rd(STAT, (|f) ? (32'h0C | f) : 32'h18);
    host.txn(8);
    tick();
    chk(alert_oe, 1'b0);
    chk(status, f);
    chk_rd(SNAP, f);
  endtask : t_alert
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  initial begin
    reset_n_i = 1'b0;
    {wr, rd, mem_end, marker, addr, wdata} = '0;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_rows();
    t_alert(32'h2, 1'b1, 1'b0, 2'h1);
    t_alert(32'h1, 1'b1, 1'b0, 2'h1);
    t_alert(32'h2, 1'b0, 1'b1, 2'h2);
    t_alert(32'h1, 1'b0, 1'b1, 2'h0);
    t_alert(32'h3, 1'b0, 1'b1, 2'h0);
    t_alert(32'h0, 1'b1, 1'b1, 2'h0);
    wrap_up();
  end
endmodule : tb_top
